// File: logic/gc_counter.sv
// Gated sixteen-bit counter with prescaler, crystal input and sync modes
`timescale 1ns/1ps
// Overview of operation
// [RL1] Count clock is divided by 1, 2, 4 or 8 per prescale select.
// [RL2] Prescale count is hidden; any count byte write clears it.
// [RL3] Crystal oscillator runs while enabled, also during sleep.
// [RL4] Software presets FC00h after clearing flag; flag rises after 1024 edges.
// [RL5] Sync bypass counts without waiting for the internal phase clock.
// [RL6] Async external counting continues in sleep and can wake the processor.
// [RL7] Mode switch may drop or add one increment.
// [RL8] Count bytes always read back a valid value.
// [RL9] Software must allow for overflow between two byte reads.
// [RL10] Software stops the counter before writing count bytes.
// [RL11] Gate enable chooses free counting or gated counting.
// [RL12] Gate polarity sets the active level of the gate input.
// [RL13] Active gate counts on source rising edges; inactive gate holds.
// [RL14] Count when gate level equals polarity bit, hold when they differ.
// [RL15] Count wraps from all ones to zero and sets a sticky overflow flag.
module gc_counter
    import gc_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire gc_ctrl_t I_CONTROL,
    input wire gc_write_t I_WRITE,
    input wire logic I_SLEEP,
    input wire logic I_COUNTER_CLOCK_PIN,
    input wire logic I_CRYSTAL_IN_PIN,
    input wire logic I_GATE_INPUT,
    output logic [BYTE_W-1:0] O_COUNT_HIGH_BYTE,
    output logic [BYTE_W-1:0] O_COUNT_LOW_BYTE,
    output logic O_OVERFLOW_FLAG,
    output logic O_WAKE,
    output logic O_CRYSTAL_RUN,
    output logic O_CRYSTAL_OUT_PIN
);

    // ------------------------------------------------------------------
    // Pin inputs
    // ------------------------------------------------------------------
    logic pin_level;
    logic xtal_level;
    logic gate_level;

    gc_pin_sync u_sync_pin (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_pin(I_COUNTER_CLOCK_PIN),
        .o_level(pin_level)
    );

    gc_pin_sync u_sync_xtal (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_pin(I_CRYSTAL_IN_PIN),
        .o_level(xtal_level)
    );

    gc_pin_sync u_sync_gate (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_pin(I_GATE_INPUT),
        .o_level(gate_level)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    gc_state_t state_reg;
    gc_state_t state_next;
    logic wr_any;
    logic phase_strobe;
    logic src_edge;
    logic gate_open;
    logic count_en;
    logic tick;
    logic apply_inc;
    logic overflow;
    logic xtal_run;

    // Oscillator is never gated by sleep
    assign xtal_run = I_CONTROL.crystal_osc_enable; // see [RL3]
    assign wr_any = I_WRITE.wr_high | I_WRITE.wr_low;
    // Internal phase clock stops in sleep, like the processor clocks
    assign phase_strobe = !I_SLEEP && (state_reg.phase == PHASE_LAST);
    // Gate compares level against polarity; disabled gate always open
    assign gate_open = !I_CONTROL.gate_enable
        || (gate_level == I_CONTROL.gate_polarity); // see [RL11] see [RL12] see [RL14]
    assign count_en = I_CONTROL.timer_on && gate_open; // see [RL13]

    // ------------------------------------------------------------------
    // Source edge selection
    // ------------------------------------------------------------------
    always_comb begin
        src_edge = 1'b0;
        unique case (I_CONTROL.clk_source)
            SRC_INSTR: begin
                src_edge = phase_strobe;
            end
            SRC_PIN: begin
                src_edge = pin_level && !state_reg.prev_pin;
            end
            SRC_XTAL: begin
                src_edge = xtal_run && xtal_level && !state_reg.prev_xtal; // see [RL3]
            end
            default: begin
                src_edge = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        tick = 1'b0;
        apply_inc = 1'b0;
        overflow = 1'b0;
        state_next.prev_pin = pin_level;
        state_next.prev_xtal = xtal_level;
        state_next.prev_bypass = I_CONTROL.sync_bypass;
        state_next.xtal_out = xtal_run && !xtal_level;
        if (!I_SLEEP) begin
            state_next.phase = state_reg.phase + 2'h1;
        end

        // Prescaler divides source edges; >= also wraps a count left by a select change
        if (count_en && src_edge) begin
            if (state_reg.presc >= gc_presc_last(I_CONTROL.prescale_select)) begin
                state_next.presc = PRESC_RESET;
                tick = 1'b1;
            end else begin
                state_next.presc = state_reg.presc + 3'h1;
            end // see [RL1]
        end

        // Bypass applies the tick at once; sync mode waits for the phase
        if (I_CONTROL.sync_bypass) begin
            apply_inc = tick; // see [RL5]
            state_next.pend = 1'b0; // see [RL7]
        end else begin
            apply_inc = phase_strobe && (state_reg.pend || tick);
            state_next.pend = (state_reg.pend || tick) && !phase_strobe;
        end

        if (apply_inc) begin
            overflow = (state_reg.count == COUNT_ALL_ONES);
            state_next.count = state_reg.count + 16'h0001; // see [RL15]
        end

        // Write takes each written byte over any coinciding increment
        if (wr_any) begin
            state_next.presc = PRESC_RESET; // see [RL2]
            state_next.pend = 1'b0;
            overflow = 1'b0;
            if (I_WRITE.wr_high) begin
                state_next.count[15:8] = I_WRITE.wr_data;
            end
            if (I_WRITE.wr_low) begin
                state_next.count[7:0] = I_WRITE.wr_data;
            end
        end

        // Set wins over a clear in the same cycle
        state_next.flag = (state_reg.flag && !I_WRITE.flag_clear) || overflow; // see [RL15]
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Bytes come straight from the count register, never mid-update
    assign O_COUNT_HIGH_BYTE = state_reg.count[15:8]; // see [RL8]
    assign O_COUNT_LOW_BYTE = state_reg.count[7:0]; // see [RL8]
    assign O_OVERFLOW_FLAG = state_reg.flag;
    // Wake only from an external source in bypass mode
    assign O_WAKE = state_reg.flag && I_SLEEP && I_CONTROL.sync_bypass
        && (I_CONTROL.clk_source != SRC_INSTR); // see [RL6]
    assign O_CRYSTAL_RUN = xtal_run;
    assign O_CRYSTAL_OUT_PIN = state_reg.xtal_out;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESETN);

    AST_WRITE_CLEARS_PRESCALE: assert property ( // see [RL2]
        wr_any |=> (state_reg.presc == PRESC_RESET) && !state_reg.pend
    ) else $error("prescale count not cleared by count write");

    AST_DIV1_STEP: assert property ( // see [RL1]
        (I_CONTROL.sync_bypass && I_CONTROL.prescale_select == PRESCALE_DIV1
            && count_en && src_edge && !wr_any && state_reg.count != COUNT_ALL_ONES)
        |=> state_reg.count == $past(state_reg.count) + 16'h0001
    ) else $error("divide-by-one edge did not step the count");

    AST_DIV8_HOLD: assert property ( // see [RL1]
        (I_CONTROL.sync_bypass && I_CONTROL.prescale_select == PRESCALE_DIV8
            && state_reg.presc != 3'h7 && !wr_any)
        |=> $stable(state_reg.count)
    ) else $error("divide-by-eight counted before prescale wrap");

    AST_SYNC_WAITS_PHASE: assert property ( // see [RL5]
        (!I_CONTROL.sync_bypass && !phase_strobe && !wr_any) |=> $stable(state_reg.count)
    ) else $error("synchronous mode counted off the phase strobe");

    AST_GATE_HOLDS: assert property ( // see [RL13] see [RL14]
        (I_CONTROL.gate_enable && gate_level != I_CONTROL.gate_polarity
            && !state_reg.pend && !wr_any) |=> $stable(state_reg.count)
    ) else $error("count moved while the gate was inactive");

    AST_WRAP_SETS_FLAG: assert property ( // see [RL15]
        (apply_inc && !wr_any && state_reg.count == COUNT_ALL_ONES)
        |=> (state_reg.count == COUNT_RESET) && state_reg.flag
    ) else $error("overflow did not wrap to zero and set the flag");

    AST_FLAG_STICKY: assert property ( // see [RL15]
        (state_reg.flag && !I_WRITE.flag_clear) |=> state_reg.flag
    ) else $error("overflow flag dropped without a clear");

    AST_SLEEP_INSTR_HOLDS: assert property ( // see [RL6]
        (I_SLEEP && I_CONTROL.clk_source == SRC_INSTR && !wr_any)
        |=> $stable(state_reg.count)
    ) else $error("instruction clock counted during sleep");

    AST_WAKE_ON_FLAG: assert property ( // see [RL6]
        (state_reg.flag && I_SLEEP && I_CONTROL.sync_bypass
            && I_CONTROL.clk_source != SRC_INSTR) |-> O_WAKE
    ) else $error("overflow in sleep did not raise wake");

    AST_XTAL_OFF_NO_COUNT: assert property ( // see [RL3]
        (I_CONTROL.clk_source == SRC_XTAL && !I_CONTROL.crystal_osc_enable
            && !state_reg.pend && !wr_any) |=> $stable(state_reg.count)
    ) else $error("crystal source counted with oscillator off");

    AST_BYPASS_NO_PEND: assert property ( // see [RL7]
        state_reg.prev_bypass |-> !state_reg.pend
    ) else $error("pending sync tick survived the bypass switch");

    AST_CLEAR_DROPS_FLAG: assert property ( // see [RL15]
        (I_WRITE.flag_clear && !overflow) |=> !state_reg.flag
    ) else $error("flag clear did not take effect");

    AST_SET_WINS: assert property ( // see [RL15]
        overflow |=> state_reg.flag
    ) else $error("overflow lost against a flag clear");

    AST_PRESC_STEP: assert property ( // see [RL1]
        (count_en && src_edge && !wr_any
            && state_reg.presc < gc_presc_last(I_CONTROL.prescale_select))
        |=> state_reg.presc == $past(state_reg.presc) + 3'h1
    ) else $error("prescale count did not step on a source edge");

    AST_GATE_OPEN_COUNTS: assert property ( // see [RL12] see [RL14]
        (I_CONTROL.sync_bypass && I_CONTROL.prescale_select == PRESCALE_DIV1
            && I_CONTROL.timer_on && I_CONTROL.gate_enable
            && gate_level == I_CONTROL.gate_polarity && src_edge && !wr_any)
        |=> state_reg.count == $past(state_reg.count) + 16'h0001
    ) else $error("open gate did not let the count step");

    AST_FREE_RUN_COUNTS: assert property ( // see [RL11]
        (I_CONTROL.sync_bypass && I_CONTROL.prescale_select == PRESCALE_DIV1
            && I_CONTROL.timer_on && !I_CONTROL.gate_enable && src_edge && !wr_any)
        |=> state_reg.count == $past(state_reg.count) + 16'h0001
    ) else $error("free-running count did not step");

    AST_SYNC_APPLIES_PEND: assert property ( // see [RL5]
        (!I_CONTROL.sync_bypass && phase_strobe && state_reg.pend && !wr_any)
        |=> state_reg.count == $past(state_reg.count) + 16'h0001
    ) else $error("pending tick not applied at the phase strobe");

    AST_WRITE_LOADS_HIGH: assert property ( // see [RL2]
        I_WRITE.wr_high |=> state_reg.count[15:8] == $past(I_WRITE.wr_data)
    ) else $error("high count byte not loaded by a write");

    AST_WRITE_LOADS_LOW: assert property ( // see [RL2]
        I_WRITE.wr_low |=> state_reg.count[7:0] == $past(I_WRITE.wr_data)
    ) else $error("low count byte not loaded by a write");

    AST_WAKE_NEEDS_SOURCE: assert property ( // see [RL6]
        O_WAKE |-> state_reg.flag && I_SLEEP && I_CONTROL.clk_source != SRC_INSTR
    ) else $error("wake raised without an external overflow in sleep");

    AST_XTAL_OUT_IDLE: assert property ( // see [RL3]
        !xtal_run |=> !O_CRYSTAL_OUT_PIN
    ) else $error("crystal drive active with the oscillator off");

    AST_XTAL_RUNS_ASLEEP: assert property ( // see [RL3]
        (I_SLEEP && I_CONTROL.crystal_osc_enable) |-> O_CRYSTAL_RUN
    ) else $error("crystal oscillator stopped during sleep");

endmodule // gc_counter

// File: inc/gc_pkg.sv
// Constants, field layouts and carrier types of the gated sixteen-bit counter
package gc_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int COUNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int PRESC_W = 3;
    localparam int PHASE_W = 2;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ALL_ONES = 16'hffff;
    localparam logic [PRESC_W-1:0] PRESC_RESET = 3'h0;
    localparam logic [PHASE_W-1:0] PHASE_RESET = 2'h0;
    localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;

    // ------------------------------------------------------------------
    // Crystal and start-up figures
    // ------------------------------------------------------------------
    localparam int XTAL_FREQ_MHZ_X1000 = 32768;
    localparam logic [COUNT_W-1:0] OSC_STARTUP_PRESET = 16'hfc00;
    localparam int OSC_STARTUP_EDGES = 1024;

    // ------------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
    localparam logic [1:0] PRESCALE_DIV2 = 2'h1;
    localparam logic [1:0] PRESCALE_DIV4 = 2'h2;
    localparam logic [1:0] PRESCALE_DIV8 = 2'h3;

    typedef enum logic [2:0] {
        SRC_INSTR = 3'b001,
        SRC_PIN = 3'b010,
        SRC_XTAL = 3'b100
    } gc_source_t;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic timer_on;
        logic [1:0] prescale_select;
        logic crystal_osc_enable;
        logic sync_bypass;
        gc_source_t clk_source;
        logic gate_enable;
        logic gate_polarity;
    } gc_ctrl_t;

    typedef struct packed {
        logic wr_high;
        logic wr_low;
        logic [BYTE_W-1:0] wr_data;
        logic flag_clear;
    } gc_write_t;

    typedef struct packed {
        logic [PHASE_W-1:0] q;
        logic level;
    } gc_sync_state_t;

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic [PRESC_W-1:0] presc;
        logic [PHASE_W-1:0] phase;
        logic pend;
        logic flag;
        logic prev_pin;
        logic prev_xtal;
        logic prev_bypass;
        logic xtal_out;
    } gc_state_t;

    // Prescale terminal value for a given select code
    function automatic logic [PRESC_W-1:0] gc_presc_last(input logic [1:0] sel);
        unique case (sel)
            PRESCALE_DIV1: gc_presc_last = 3'h0;
            PRESCALE_DIV2: gc_presc_last = 3'h1;
            PRESCALE_DIV4: gc_presc_last = 3'h3;
            PRESCALE_DIV8: gc_presc_last = 3'h7;
        endcase
    endfunction

endpackage

// File: logic/gc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gc_pin_sync
    import gc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_pin,
    output logic o_level
);

    gc_sync_state_t state_reg;
    gc_sync_state_t state_next;
    logic stage1_reg;

    // ------------------------------------------------------------------
    // First stage, read only by the second
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stage1_reg <= 1'b0;
        end else begin
            stage1_reg <= i_pin;
        end
    end

    // ------------------------------------------------------------------
    // Second and third stages, level follows only on agreement
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.q = {state_reg.q[0], stage1_reg};
        if (state_reg.q[0] == state_reg.q[1]) begin
            state_next.level = state_reg.q[1];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_level = state_reg.level;

endmodule // gc_pin_sync

// File: bench/gc_counter_tb_top.sv
// Self-checking testbench of the gated sixteen-bit counter
`timescale 1ns/1ps
module gc_counter_tb_top;
    import gc_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic resetn = 1'b0;
    gc_ctrl_t ctl = '{1'b1, PRESCALE_DIV1, 1'b0, 1'b1, SRC_PIN, 1'b0, 1'b0};
    gc_write_t wr_s = '0;
    logic sleep = 1'b0;
    logic pin = 1'b0;
    logic xtal = 1'b0;
    logic gate = 1'b0;
    logic [BYTE_W-1:0] cnt_hi;
    logic [BYTE_W-1:0] cnt_lo;
    logic flag;
    logic wake;
    logic run;
    logic xout;
    logic [19:0] notes[$];
    int failures = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h2d40e34f;
    event ev;

    gc_counter dut_u (
        .I_CLK(clk),
        .I_RESETN(resetn),
        .I_CONTROL(ctl),
        .I_WRITE(wr_s),
        .I_SLEEP(sleep),
        .I_COUNTER_CLOCK_PIN(pin),
        .I_CRYSTAL_IN_PIN(xtal),
        .I_GATE_INPUT(gate),
        .O_COUNT_HIGH_BYTE(cnt_hi),
        .O_COUNT_LOW_BYTE(cnt_lo),
        .O_OVERFLOW_FLAG(flag),
        .O_WAKE(wake),
        .O_CRYSTAL_RUN(run),
        .O_CRYSTAL_OUT_PIN(xout)
    );

    initial begin
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        xs = s ^ (s << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Wake and crystal run are derived here, never read back from the design
    // Crystal input rests low between edges, so its drive pin rests at the enable
    task automatic note(input logic [15:0] c, input logic f);
        logic w;
        w = f & sleep & ctl.sync_bypass & (ctl.clk_source != SRC_INSTR);
        notes.push_back({ctl.crystal_osc_enable, ctl.crystal_osc_enable, w, f, c});
        ->ev;
        // Inputs stay still until the check has run
        cyc(1);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wr(input logic hi, input logic lo, input logic [7:0] d);
        wr_s = '{hi, lo, d, 1'b0};
        cyc(1);
        wr_s = '0;
        cyc(1);
    endtask

    task automatic setw(input logic [15:0] v);
        ctl.timer_on = 1'b0;
        wr(1'b1, 1'b0, v[15:8]);
        wr(1'b0, 1'b1, v[7:0]);
        ctl.timer_on = 1'b1;
    endtask

    task automatic clr_flag();
        wr_s.flag_clear = 1'b1;
        cyc(1);
        wr_s = '0;
        cyc(1);
    endtask

    // Slow edges: the pin synchroniser needs several cycles to see each level
    task automatic edges(input int n, input logic x);
        for (int i = 0; i < n; i++) begin
            if (x) xtal = 1'b1;
            else pin = 1'b1;
            cyc(6);
            xtal = 1'b0;
            pin = 1'b0;
            cyc(6);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        forever begin
            @(ev);
            while (notes.size() > 0) begin
                check({12'h0, xout, run, wake, flag, cnt_hi, cnt_lo},
                    {12'h0, notes.pop_front()});
            end
        end
    end

    initial begin
        #800us;
        failures++;
        end_of_test();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        int n;
        logic [15:0] p;
        repeat (4) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        cyc(1);
        note(16'h0000, 1'b0);
        for (int s = 0; s < 4; s++) begin
            ctl.prescale_select = 2'(s);
            setw(16'h0000);
            edges(8, 1'b0);
            note(16'(8 >> s), 1'b0);
        end
        // Partial prescale count must not survive a count write
        ctl.prescale_select = PRESCALE_DIV4;
        setw(16'h0000);
        edges(3, 1'b0);
        ctl.timer_on = 1'b0;
        wr(1'b0, 1'b1, 8'h00);
        ctl.timer_on = 1'b1;
        edges(1, 1'b0);
        note(16'h0000, 1'b0);
        edges(3, 1'b0);
        note(16'h0001, 1'b0);
        ctl.prescale_select = PRESCALE_DIV1;
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            ctl.gate_enable = k[2];
            ctl.gate_polarity = k[0];
            gate = k[1];
            n = 1 + int'(seed[10:8]);
            p = seed[31:16] & 16'h7fff;
            setw(p);
            cyc(6);
            edges(n, 1'b0);
            note((!ctl.gate_enable || gate == ctl.gate_polarity) ? p + 16'(n) : p,
                1'b0);
        end
        ctl.gate_enable = 1'b0;
        ctl.sync_bypass = 1'b0;
        ctl.prescale_select = PRESCALE_DIV2;
        setw(16'h0000);
        edges(6, 1'b0);
        note(16'h0003, 1'b0);
        ctl.sync_bypass = 1'b1;
        ctl.prescale_select = PRESCALE_DIV1;
        setw(16'hfffe);
        edges(1, 1'b0);
        note(16'hffff, 1'b0);
        edges(1, 1'b0);
        note(16'h0000, 1'b1);
        edges(2, 1'b0);
        note(16'h0002, 1'b1);
        clr_flag();
        note(16'h0002, 1'b0);
        // Instruction clock: frozen in sleep, one step per four cycles awake
        sleep = 1'b1;
        ctl.clk_source = SRC_INSTR;
        setw(16'h0000);
        cyc(20);
        note(16'h0000, 1'b0);
        sleep = 1'b0;
        cyc(40);
        note(16'h000a, 1'b0);
        // Crystal start-up wait, run while asleep
        ctl.crystal_osc_enable = 1'b1;
        ctl.clk_source = SRC_XTAL;
        sleep = 1'b1;
        clr_flag();
        setw(OSC_STARTUP_PRESET);
        edges(OSC_STARTUP_EDGES - 1, 1'b1);
        note(16'hffff, 1'b0);
        edges(1, 1'b1);
        note(16'h0000, 1'b1);
        sleep = 1'b0;
        cyc(1);
        note(16'h0000, 1'b1);
        ctl.crystal_osc_enable = 1'b0;
        edges(2, 1'b1);
        note(16'h0000, 1'b1);
        cyc(2);
        end_of_test();
    end
endmodule // gc_counter_tb_top
